// >>> include/supervisor_pkg.sv
// Shared constants and types for the supply supervisor with serial memory.
// Assumes a single 200 MHz system clock and a synchronous active-low reset.
package supervisor_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] CLK_KHZ = 32'd200000;       // 200 MHz system clock
  localparam logic [31:0] REL_DELAY_MS = 32'd200;     // Reset release delay
  localparam logic [31:0] WDOG_TIMEOUT_MS = 32'd1600; // Watchdog timeout, 1.6 s
  localparam logic [31:0] REL_CYC = REL_DELAY_MS * CLK_KHZ;
  localparam logic [31:0] WDOG_CYC = WDOG_TIMEOUT_MS * CLK_KHZ;
  localparam logic [2:0] MR_GUARD_CYC = 3'h4;          // Pin settle time after release

  // ----------------------------------------------------------------
  // Memory and serial bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;                  // 2k bits = 256 bytes
  localparam int MEM_BYTES = 256;
  localparam int PAGE_W = 4;                  // 16-byte page
  localparam logic [6:0] DEV_ADDR = 7'h50;    // Serial bus slave address
  localparam logic [3:0] BITS_BYTE = 4'h7;    // Index of last bit of a byte
  localparam logic [3:0] ACK_WAIT = 4'h8;     // Ack slot pending
  localparam logic [3:0] ACK_DRIVE = 4'h9;    // Ack slot being driven

  // ----------------------------------------------------------------
  // Reset values of output flops
  // ----------------------------------------------------------------
  localparam logic RST_LO_OE_N_INIT = 1'b0;   // Reset pin sunk during reset
  localparam logic RELEASED = 1'b1;           // Open-drain pin released

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SV_HOLD, SV_DELAY, SV_RUN} sv_state_e;

  typedef enum logic [2:0] {
    I_IDLE, I_DEV, I_WADDR, I_WDATA, I_ACK, I_RDATA, I_MACK, I_IGNORE
  } i2c_state_e;

  typedef struct packed {
    logic supply_low;
    logic aux_low;
    logic rst_pin_n;
    logic kick;
    logic scl;
    logic sda;
  } pin_sync_s;

endpackage : supervisor_pkg

// >>> src/nvm_array.sv
// Byte-wide nonvolatile array model, one write port, registered read.
// Assumes the caller has already gated writes against low supply.
module nvm_array (
  input wire logic clk_sys, // System clock
  input wire logic we, // Write strobe
  input wire logic [supervisor_pkg::ADDR_W-1:0] waddr, // Write address
  input wire logic [7:0] wdata, // Write data
  input wire logic [supervisor_pkg::ADDR_W-1:0] raddr, // Read address
  output logic [7:0] rdata // Registered read data
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] mem [supervisor_pkg::MEM_BYTES];

  // Write and registered read
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : nvm_array

// >>> src/supply_supervisor.sv
// Supply supervisor: reset generation, watchdog, auxiliary flag, memory port.
// Assumes comparator levels, reset pin readback and bus pins are asynchronous.
module supply_supervisor #(
  parameter logic [31:0] REL_CYC = supervisor_pkg::REL_CYC, // Release delay in cycles
  parameter logic [31:0] WDOG_CYC = supervisor_pkg::WDOG_CYC, // Watchdog timeout in cycles
  parameter bit HAS_WATCHDOG = 1'b0 // 1 selects the single-output variant
) (
  input wire logic clk_sys, // System clock, 200 MHz
  input wire logic rstn, // Synchronous reset, active low
  input wire logic supply_low, // Supply comparator, high when below threshold
  input wire logic aux_low, // Auxiliary comparator, high when below 1.25 V
  input wire logic rst_n_i, // Active-low reset pin readback
  output logic rst_n_o, // Active-low reset pin level when enabled
  output logic rst_n_oe_n, // Active-low reset pin enable, low sinks
  output logic rst_hi_o, // Active-high reset pin level when enabled
  output logic rst_hi_oe_n, // Active-high reset pin enable, low drives
  output logic aux_low_n_o, // Auxiliary flag pin level when enabled
  output logic aux_low_n_oe_n, // Auxiliary flag pin enable, low sinks
  input wire logic watchdog_kick_input, // Watchdog kick pin
  input wire logic scl_i, // Serial clock pin
  input wire logic sda_i, // Serial data pin readback
  output logic sda_o, // Serial data pin level when enabled
  output logic sda_oe_n // Serial data pin enable, low sinks
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  supervisor_pkg::pin_sync_s sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
  logic kick_prev_ff, scl_prev_ff, sda_prev_ff;
  logic nxt_kick_prev, nxt_scl_prev, nxt_sda_prev;
  logic kick_edge, scl_rise, scl_fall, bus_start, bus_stop;

  supervisor_pkg::sv_state_e sv_state_ff, nxt_sv_state;
  logic [31:0] rel_cnt_ff, nxt_rel_cnt;
  logic [31:0] wd_cnt_ff, nxt_wd_cnt;
  logic [2:0] guard_ff, nxt_guard;
  logic rst_n_oe_n_ff, nxt_rst_n_oe_n;
  logic rst_hi_oe_n_ff, nxt_rst_hi_oe_n;
  logic aux_oe_n_ff, nxt_aux_oe_n;
  logic od_lvl_ff, hi_lvl_ff;

  supervisor_pkg::i2c_state_e i2c_state_ff, nxt_i2c_state;
  supervisor_pkg::i2c_state_e after_ack_ff, nxt_after_ack;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] addr_ff, nxt_addr;
  logic sda_oe_n_ff, nxt_sda_oe_n;
  logic mem_we;
  logic [7:0] mem_wdata, mem_rdata;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Next address inside the current page, low bits wrap
  function automatic logic [7:0] page_next(input logic [7:0] a);
    page_next = {a[7:supervisor_pkg::PAGE_W], a[supervisor_pkg::PAGE_W-1:0] + 4'h1};
  endfunction : page_next

  // ----------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------
  // Two stages for every asynchronous pin, third stage for edges
  always_comb begin
    nxt_sync1 = '{supply_low: supply_low, aux_low: aux_low, rst_pin_n: rst_n_i,
                  kick: watchdog_kick_input, scl: scl_i, sda: sda_i};
    nxt_sync2 = sync1_ff;
    nxt_kick_prev = sync2_ff.kick;
    nxt_scl_prev = sync2_ff.scl;
    nxt_sda_prev = sync2_ff.sda;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      // Flag comparator starts at its released level so the flag pin does not sink right after reset
      sync1_ff <= '{supply_low: 1'b1, aux_low: 1'b0, rst_pin_n: 1'b1, kick: 1'b0, scl: 1'b1, sda: 1'b1};
      sync2_ff <= '{supply_low: 1'b1, aux_low: 1'b0, rst_pin_n: 1'b1, kick: 1'b0, scl: 1'b1, sda: 1'b1};
      kick_prev_ff <= 1'b0;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      kick_prev_ff <= nxt_kick_prev;
      scl_prev_ff <= nxt_scl_prev;
      sda_prev_ff <= nxt_sda_prev;
    end
  end

  // Edge and bus condition decode
  assign kick_edge = sync2_ff.kick ^ kick_prev_ff;
  assign scl_rise = sync2_ff.scl & ~scl_prev_ff;
  assign scl_fall = ~sync2_ff.scl & scl_prev_ff;
  assign bus_start = sync2_ff.scl & scl_prev_ff & sda_prev_ff & ~sync2_ff.sda;
  assign bus_stop = sync2_ff.scl & scl_prev_ff & ~sda_prev_ff & sync2_ff.sda;

  // ----------------------------------------------------------------
  // Reset sequencer and watchdog
  // ----------------------------------------------------------------
  // Hold while supply low, count release delay, then run
  always_comb begin
    nxt_sv_state = sv_state_ff;
    nxt_rel_cnt = rel_cnt_ff;
    nxt_wd_cnt = wd_cnt_ff;
    nxt_guard = guard_ff;
    case (sv_state_ff)
      supervisor_pkg::SV_HOLD: begin
        nxt_rel_cnt = '0;
        if (!sync2_ff.supply_low) begin
          nxt_sv_state = supervisor_pkg::SV_DELAY;
        end
      end
      supervisor_pkg::SV_DELAY: begin
        if (sync2_ff.supply_low) begin
          nxt_sv_state = supervisor_pkg::SV_HOLD;
        end else if (rel_cnt_ff == REL_CYC - 32'h1) begin
          nxt_sv_state = supervisor_pkg::SV_RUN;
          nxt_guard = '0;
          nxt_wd_cnt = '0;
        end else begin
          nxt_rel_cnt = rel_cnt_ff + 32'h1;
        end
      end
      supervisor_pkg::SV_RUN: begin
        if (guard_ff != supervisor_pkg::MR_GUARD_CYC) begin
          nxt_guard = guard_ff + 3'h1;
        end
        if (kick_edge) begin
          nxt_wd_cnt = '0;
        end else begin
          nxt_wd_cnt = wd_cnt_ff + 32'h1;
        end
        if (sync2_ff.supply_low) begin
          nxt_sv_state = supervisor_pkg::SV_HOLD;
        end else if (guard_ff == supervisor_pkg::MR_GUARD_CYC && !sync2_ff.rst_pin_n) begin
          nxt_sv_state = supervisor_pkg::SV_DELAY;
          nxt_rel_cnt = '0;
        end else if (HAS_WATCHDOG && !kick_edge && wd_cnt_ff == WDOG_CYC - 32'h1) begin
          nxt_sv_state = supervisor_pkg::SV_DELAY;
          nxt_rel_cnt = '0;
        end
      end
      default: begin
        nxt_sv_state = supervisor_pkg::SV_HOLD;
      end
    endcase
  end

  // Reset pin enables follow the next state so pins change with it (high pin held released when HAS_WATCHDOG), flag enable follows the synchronised comparator
  always_comb begin
    nxt_rst_n_oe_n = (nxt_sv_state == supervisor_pkg::SV_RUN);
    nxt_rst_hi_oe_n = HAS_WATCHDOG || (nxt_sv_state == supervisor_pkg::SV_RUN);
    nxt_aux_oe_n = ~sync2_ff.aux_low;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sv_state_ff <= supervisor_pkg::SV_HOLD;
      rel_cnt_ff <= '0;
      wd_cnt_ff <= '0;
      guard_ff <= '0;
      rst_n_oe_n_ff <= supervisor_pkg::RST_LO_OE_N_INIT;
      rst_hi_oe_n_ff <= HAS_WATCHDOG;
      aux_oe_n_ff <= supervisor_pkg::RELEASED;
      od_lvl_ff <= 1'b0;
      hi_lvl_ff <= 1'b1;
    end else begin
      sv_state_ff <= nxt_sv_state;
      rel_cnt_ff <= nxt_rel_cnt;
      wd_cnt_ff <= nxt_wd_cnt;
      guard_ff <= nxt_guard;
      rst_n_oe_n_ff <= nxt_rst_n_oe_n;
      rst_hi_oe_n_ff <= nxt_rst_hi_oe_n;
      aux_oe_n_ff <= nxt_aux_oe_n;
      od_lvl_ff <= 1'b0;
      hi_lvl_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Serial memory slave
  // ----------------------------------------------------------------
  // Bit engine: sample on clock rise, drive on clock fall
  always_comb begin
    nxt_i2c_state = i2c_state_ff;
    nxt_after_ack = after_ack_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_addr = addr_ff;
    nxt_sda_oe_n = sda_oe_n_ff;
    mem_we = 1'b0;
    mem_wdata = {shift_ff[6:0], sync2_ff.sda};
    if (bus_stop) begin
      nxt_i2c_state = supervisor_pkg::I_IDLE;
      nxt_sda_oe_n = 1'b1;
    end else if (bus_start) begin
      nxt_i2c_state = supervisor_pkg::I_DEV;
      nxt_bit_cnt = '0;
      nxt_sda_oe_n = 1'b1;
    end else begin
      case (i2c_state_ff)
        supervisor_pkg::I_DEV, supervisor_pkg::I_WADDR, supervisor_pkg::I_WDATA: begin
          if (scl_rise) begin
            nxt_shift = mem_wdata;
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == supervisor_pkg::BITS_BYTE) begin
              nxt_i2c_state = supervisor_pkg::I_ACK;
              nxt_bit_cnt = supervisor_pkg::ACK_WAIT;
              if (i2c_state_ff == supervisor_pkg::I_DEV) begin
                if (shift_ff[6:0] != supervisor_pkg::DEV_ADDR) begin
                  nxt_i2c_state = supervisor_pkg::I_IGNORE;
                end else if (sync2_ff.sda) begin
                  nxt_after_ack = supervisor_pkg::I_RDATA;
                end else begin
                  nxt_after_ack = supervisor_pkg::I_WADDR;
                end
              end else if (i2c_state_ff == supervisor_pkg::I_WADDR) begin
                nxt_addr = mem_wdata;
                nxt_after_ack = supervisor_pkg::I_WDATA;
              end else begin
                mem_we = ~sync2_ff.supply_low;
                nxt_addr = page_next(addr_ff);
                nxt_after_ack = supervisor_pkg::I_WDATA;
              end
            end
          end
        end
        supervisor_pkg::I_ACK: begin
          if (scl_fall && bit_cnt_ff == supervisor_pkg::ACK_WAIT) begin
            nxt_sda_oe_n = 1'b0;
            nxt_bit_cnt = supervisor_pkg::ACK_DRIVE;
          end else if (scl_fall) begin
            nxt_i2c_state = after_ack_ff;
            nxt_bit_cnt = '0;
            nxt_sda_oe_n = 1'b1;
            if (after_ack_ff == supervisor_pkg::I_RDATA) begin
              nxt_shift = mem_rdata;
              nxt_sda_oe_n = mem_rdata[7];
            end
          end
        end
        supervisor_pkg::I_RDATA: begin
          if (scl_rise) begin
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == supervisor_pkg::ACK_WAIT) begin
            nxt_sda_oe_n = 1'b1;
            nxt_i2c_state = supervisor_pkg::I_MACK;
          end else if (scl_fall) begin
            nxt_shift = {shift_ff[6:0], 1'b0};
            nxt_sda_oe_n = shift_ff[6];
          end
        end
        supervisor_pkg::I_MACK: begin
          if (scl_rise && sync2_ff.sda) begin
            nxt_i2c_state = supervisor_pkg::I_IGNORE;
          end else if (scl_rise) begin
            nxt_addr = addr_ff + 8'h1;
            nxt_i2c_state = supervisor_pkg::I_ACK;
            nxt_bit_cnt = supervisor_pkg::ACK_DRIVE;
            nxt_after_ack = supervisor_pkg::I_RDATA;
          end
        end
        supervisor_pkg::I_IDLE, supervisor_pkg::I_IGNORE: begin
          nxt_sda_oe_n = 1'b1;
        end
        default: begin
          nxt_i2c_state = supervisor_pkg::I_IDLE;
          nxt_sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      i2c_state_ff <= supervisor_pkg::I_IDLE;
      after_ack_ff <= supervisor_pkg::I_IDLE;
      bit_cnt_ff <= '0;
      shift_ff <= '0;
      addr_ff <= '0;
      sda_oe_n_ff <= supervisor_pkg::RELEASED;
    end else begin
      i2c_state_ff <= nxt_i2c_state;
      after_ack_ff <= nxt_after_ack;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      addr_ff <= nxt_addr;
      sda_oe_n_ff <= nxt_sda_oe_n;
    end
  end

  // Byte array, written at the last data bit of each byte
  nvm_array u_nvm (
    .clk_sys(clk_sys),
    .we(mem_we),
    .waddr(addr_ff),
    .wdata(mem_wdata),
    .raddr(addr_ff),
    .rdata(mem_rdata)
  );

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  // Open-drain levels are always low, enables select sink or release
  assign rst_n_o = od_lvl_ff;
  assign rst_n_oe_n = rst_n_oe_n_ff;
  assign rst_hi_o = hi_lvl_ff;
  assign rst_hi_oe_n = rst_hi_oe_n_ff;
  assign aux_low_n_o = od_lvl_ff;
  assign aux_low_n_oe_n = aux_oe_n_ff;
  assign sda_o = od_lvl_ff;
  assign sda_oe_n = sda_oe_n_ff;

endmodule : supply_supervisor

// >>> verif/supply_supervisor_checker.sv
// Concurrent checks on the reset, watchdog, flag and data pins of the supervisor.
// Assumes one clock domain and a pulled-up reset wire read back on rst_n_i.
module supply_supervisor_checker #(
  parameter logic [31:0] REL_CYC = 32'h0000_00c8, // Release delay in cycles
  parameter logic [31:0] WDOG_CYC = 32'h0000_03e8, // Watchdog timeout in cycles
  parameter bit HAS_WATCHDOG = 1'b0 // Single-output variant
) (
  input wire logic clk_sys, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic supply_low, // Supply comparator
  input wire logic aux_low, // Auxiliary comparator
  input wire logic rst_n_i, // Reset wire readback
  input wire logic rst_n_o, // Reset pin level
  input wire logic rst_n_oe_n, // Reset pin sink enable
  input wire logic rst_hi_o, // High reset pin level
  input wire logic rst_hi_oe_n, // High reset pin enable
  input wire logic aux_low_n_o, // Flag pin level
  input wire logic aux_low_n_oe_n, // Flag pin enable
  input wire logic watchdog_kick_input, // Kick pin
  input wire logic scl_i, // Serial clock
  input wire logic sda_i, // Serial data readback
  input wire logic sda_o, // Serial data level
  input wire logic sda_oe_n // Serial data enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  logic [31:0] low_cnt_ff, nxt_low_cnt;
  logic [31:0] idle_cnt_ff, nxt_idle_cnt;
  logic [3:0] cause_cnt_ff, nxt_cause_cnt;
  logic kick_ff, nxt_kick;

  // Cycles of good supply, cycles since a kick edge, cycles since a reset cause
  always_comb begin
    nxt_low_cnt = supply_low ? 32'h0 : low_cnt_ff + 32'h1;
    nxt_idle_cnt = (!rst_n_oe_n || watchdog_kick_input != kick_ff) ? 32'h0 : idle_cnt_ff + 32'h1;
    nxt_cause_cnt = (supply_low || (rst_n_oe_n && !rst_n_i)) ? 4'h0 : cause_cnt_ff + {3'h0, cause_cnt_ff != 4'hf};
    nxt_kick = watchdog_kick_input;
  end

  // Helper registers
  always_ff @(posedge clk_sys) begin
    low_cnt_ff <= rstn ? nxt_low_cnt : 32'h0;
    idle_cnt_ff <= rstn ? nxt_idle_cnt : 32'h0;
    cause_cnt_ff <= rstn ? nxt_cause_cnt : 4'h0;
    kick_ff <= nxt_kick;
  end

  sequence s_supply_bad;
    supply_low [*6];
  endsequence
  sequence s_push;
    $fell(rst_n_i) && rst_n_oe_n;
  endsequence

  chk_hold_low: assert property (s_supply_bad |-> !rst_n_oe_n)
    else $error("reset not asserted while supply low");
  chk_release_delay: assert property ($rose(rst_n_oe_n) |-> low_cnt_ff >= REL_CYC)
    else $error("reset released before the delay ran out");
  chk_open_drain: assert property (!rst_n_o && rst_hi_o && !aux_low_n_o && !sda_o)
    else $error("open-drain pin level not the sink level");
  chk_variant_pins: assert property (rst_hi_oe_n == (HAS_WATCHDOG ? 1'b1 : rst_n_oe_n))
    else $error("high reset pin disagrees with variant");
  chk_aux_low: assert property (aux_low [*5] |-> !aux_low_n_oe_n)
    else $error("flag not pulled low");
  chk_aux_high: assert property ((!aux_low) [*5] |-> aux_low_n_oe_n)
    else $error("flag not released");
  chk_manual_push: assert property (s_push |-> ##[1:6] !rst_n_oe_n)
    else $error("pushed reset pin not taken");
  chk_wdog_limit: assert property (!HAS_WATCHDOG || idle_cnt_ff <= WDOG_CYC + 32'h8)
    else $error("watchdog did not expire");
  chk_wdog_early: assert property ($fell(rst_n_oe_n) |-> cause_cnt_ff < 4'h8 || idle_cnt_ff + 32'h8 >= WDOG_CYC)
    else $error("reset without cause");
  chk_bus_quiet: assert property ((scl_i && sda_i) [*8] |-> sda_oe_n)
    else $error("data line sunk on an idle bus");
endmodule : supply_supervisor_checker

bind supply_supervisor supply_supervisor_checker #(
  .REL_CYC(REL_CYC), .WDOG_CYC(WDOG_CYC), .HAS_WATCHDOG(HAS_WATCHDOG)) chk_u (.*);

// >>> verif/mcu_model.sv
// Host microcontroller model: reset button on the pulled-up wire and kick pin.
// Assumes the supervisor sinks the reset wire when its enable is low.
module mcu_model #(
  parameter int KICK_GAP = 300 // One less than the cycles between kick edges
) (
  input wire logic clk_sys, // Clock
  input wire logic rst_n_oe_n, // Supervisor sinks wire when low
  input wire logic push, // Button held
  input wire logic kick_en, // Keep the watchdog fed
  output logic rst_n_wire, // Resolved reset wire
  output logic kick // Kick pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap_cnt = 0;
  logic kick_ff = 1'b0;

  // Wired-AND over the pull-up: either party may sink it
  assign rst_n_wire = rst_n_oe_n && !push;
  assign kick = kick_ff;

  // Toggle the kick pin on a steady cadence while enabled
  always @(negedge clk_sys) begin
    gap_cnt <= (gap_cnt >= KICK_GAP) ? 0 : gap_cnt + 1;
    if (kick_en && gap_cnt >= KICK_GAP) begin
      kick_ff <= !kick_ff;
    end
  end
endmodule : mcu_model

// >>> verif/testbench.sv
// Self-checking bench for the supervisor in its single-output watchdog form.
// Assumes shortened release and watchdog counts; the bench is the serial bus master.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] REL = 32'h0000_00c8;
  localparam logic [31:0] WDOG = 32'h0000_03e8;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic supply_low = 1'b1;
  logic aux_low = 1'b0;
  logic push = 1'b0;
  logic kick_en = 1'b1;
  logic rst_n_i, rst_n_o, rst_n_oe_n, rst_hi_o, rst_hi_oe_n;
  logic aux_low_n_o, aux_low_n_oe_n, kick, sda_o, sda_oe_n;
  int fail_count = 0;
  int total_checks = 0;
  logic scl = 1'b1;
  logic sda_m = 1'b1;
  logic sda_bus;

  // Wired-AND data line: master and device may each sink it
  assign sda_bus = sda_m & sda_oe_n;

  always #2.5 clk_sys = ~clk_sys;

  supply_supervisor #(.REL_CYC(REL), .WDOG_CYC(WDOG), .HAS_WATCHDOG(1'b1)) dut_u (
    .clk_sys(clk_sys), .rstn(rstn), .supply_low(supply_low), .aux_low(aux_low),
    .rst_n_i(rst_n_i), .rst_n_o(rst_n_o), .rst_n_oe_n(rst_n_oe_n), .rst_hi_o(rst_hi_o),
    .rst_hi_oe_n(rst_hi_oe_n), .aux_low_n_o(aux_low_n_o), .aux_low_n_oe_n(aux_low_n_oe_n),
    .watchdog_kick_input(kick), .scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o), .sda_oe_n(sda_oe_n));

  mcu_model #(.KICK_GAP(300)) partner_u (.clk_sys(clk_sys), .rst_n_oe_n(rst_n_oe_n), .push(push),
    .kick_en(kick_en), .rst_n_wire(rst_n_i), .kick(kick));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  // Count cycles until the reset wire is let go
  task automatic wait_release(output logic [31:0] n);
    n = 32'h0;
    while (rst_n_oe_n !== 1'b1 && n < 32'h1388) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : wait_release

  task automatic t_power_up;
    logic [31:0] n;
    cyc(10);
    check(rst_n_oe_n, 32'h0);
    check(rst_hi_oe_n, 32'h1);
    check({rst_n_o, rst_hi_o, aux_low_n_o, sda_o}, 32'h4);
    supply_low = 1'b0;
    wait_release(n);
    check(n >= REL && n <= REL + 32'h8, 32'h1);
  endtask : t_power_up

  task automatic t_brownout;
    logic [31:0] n;
    cyc(20);
    supply_low = 1'b1;
    cyc(6);
    check(rst_n_oe_n, 32'h0);
    supply_low = 1'b0;
    cyc(100);
    supply_low = 1'b1;
    cyc(10);
    supply_low = 1'b0;
    wait_release(n);
    check(n >= REL && n <= REL + 32'h8, 32'h1);
  endtask : t_brownout

  task automatic t_manual;
    logic [31:0] n;
    cyc(20);
    push = 1'b1;
    cyc(2);
    push = 1'b0;
    cyc(6);
    check(rst_n_oe_n, 32'h0);
    wait_release(n);
    check(n + 32'ha >= REL && n <= REL, 32'h1);
  endtask : t_manual

  task automatic t_kick_fed;
    logic [31:0] bad;
    bad = 32'h0;
    repeat (3000) begin
      @(negedge clk_sys);
      if (rst_n_oe_n !== 1'b1) bad++;
    end
    check(bad, 32'h0);
  endtask : t_kick_fed

  task automatic t_starve;
    logic [31:0] n;
    @(kick);
    @(negedge clk_sys);
    kick_en = 1'b0;
    n = 32'h0;
    while (rst_n_oe_n === 1'b1 && n < 32'h1388) begin
      @(negedge clk_sys);
      n++;
    end
    check(n + 32'h2 >= WDOG && n <= WDOG + 32'h8, 32'h1);
    kick_en = 1'b1;
    wait_release(n);
    check(n + 32'ha >= REL && n <= REL + 32'h8, 32'h1);
  endtask : t_starve

  task automatic t_aux;
    aux_low = 1'b1;
    cyc(5);
    check(aux_low_n_oe_n, 32'h0);
    aux_low = 1'b0;
    cyc(5);
    check(aux_low_n_oe_n, 32'h1);
  endtask : t_aux

  // Serial bus master: start, stop and one byte plus its acknowledge slot
  task automatic i2c_start;
    sda_m = 1'b1;
    scl = 1'b1;
    cyc(8);
    sda_m = 1'b0;
    cyc(8);
    scl = 1'b0;
    cyc(8);
  endtask : i2c_start

  task automatic i2c_stop;
    sda_m = 1'b0;
    cyc(8);
    scl = 1'b1;
    cyc(8);
    sda_m = 1'b1;
    cyc(8);
  endtask : i2c_stop

  task automatic i2c_byte(input logic [7:0] d, input logic a, output logic [8:0] r);
    logic [8:0] bits;
    bits = {d, a};
    for (int i = 8; i >= 0; i--) begin
      sda_m = bits[i];
      cyc(8);
      scl = 1'b1;
      cyc(4);
      r[i] = sda_bus;
      cyc(4);
      scl = 1'b0;
    end
  endtask : i2c_byte

  task automatic t_serial;
    logic [8:0] r;
    logic [31:0] n;
    i2c_start();
    i2c_byte(8'h90, 1'b1, r);
    check({31'h0, r[0]}, 32'h1);
    i2c_stop();
    i2c_start();
    i2c_byte(8'ha0, 1'b1, r);
    check({31'h0, r[0]}, 32'h0);
    i2c_byte(8'h0e, 1'b1, r);
    i2c_byte(8'h11, 1'b1, r);
    i2c_byte(8'h22, 1'b1, r);
    i2c_byte(8'h33, 1'b1, r);
    check({31'h0, r[0]}, 32'h0);
    i2c_stop();
    supply_low = 1'b1;
    cyc(6);
    i2c_start();
    i2c_byte(8'ha0, 1'b1, r);
    i2c_byte(8'h0e, 1'b1, r);
    i2c_byte(8'h77, 1'b1, r);
    i2c_stop();
    supply_low = 1'b0;
    wait_release(n);
    i2c_start();
    i2c_byte(8'ha0, 1'b1, r);
    i2c_byte(8'h0e, 1'b1, r);
    i2c_stop();
    i2c_start();
    i2c_byte(8'ha1, 1'b1, r);
    check({31'h0, r[0]}, 32'h0);
    i2c_byte(8'hff, 1'b0, r);
    check({24'h0, r[8:1]}, 32'h11);
    i2c_byte(8'hff, 1'b1, r);
    check({24'h0, r[8:1]}, 32'h22);
    i2c_stop();
    i2c_start();
    i2c_byte(8'ha0, 1'b1, r);
    i2c_byte(8'h00, 1'b1, r);
    i2c_stop();
    i2c_start();
    i2c_byte(8'ha1, 1'b1, r);
    i2c_byte(8'hff, 1'b1, r);
    check({24'h0, r[8:1]}, 32'h33);
    i2c_stop();
  endtask : t_serial

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    cyc(3);
    rstn = 1'b1;
    t_power_up();
    t_aux();
    t_serial();
    t_brownout();
    t_manual();
    t_kick_fed();
    t_starve();
    summarize();
  end

  // Hang guard
  initial begin
    #200us;
    fail_count++;
    summarize();
  end
endmodule : testbench
